// [cpu_instruction_timing.sv]
// Instruction sequencer: per-opcode byte and cycle timing of the core
// Contract
// - Opcodes keep standard encoding, addressing mode and flag effects.
// - Execution time counts single clock cycles, no machine cycle groups.
// - Most instructions take as many cycles as program bytes.
// - Taken conditional branch takes two cycles more than not taken.
// - External data move reaches on-chip RAM, off-chip memory, flash.
// - Add and add with carry: reg 1/1, direct/immediate 2/2, indirect 1/2.
// - Subtract-with-borrow uses the same counts as addition.
// - Logic op to direct byte: immediate 3/3, accumulator source 2/2.
// - Clear, complement, rotates and nibble swap take 1 byte, 1 cycle; clear and complement of a direct bit take 2/2.
// - Direct to direct move takes 3 bytes, 3 cycles.
// - Accumulator to indirect RAM takes 1 byte, 2 cycles.
// - Loading data pointer with 16-bit constant takes 3 bytes, 3 cycles.
// - Code byte read into accumulator takes 1 byte, 3 cycles.
// - External data reads and writes take 1 byte, 3 cycles.
// - Push and pop of a direct byte take 2 bytes, 2 cycles.
// - Exchange with register 1/1; with direct byte 2/2.
// - Exchange or low nibble exchange with indirect RAM takes 1/2.
`timescale 1ns/100ps
module cpu_instruction_timing #(
	parameter logic        HAS_EXT_IF = 1'b1,
	parameter logic [15:0] EXT_RAM_LIMIT = cpu_timing_pkg::EXT_RAM_LIMIT_DEFAULT
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  resetn,
	// Opcode hand-off
	input  wire logic                  op_valid,
	input  wire logic [7:0]            op_byte,
	input  wire logic                  branch_cond_true,
	output logic                       op_ready_r,
	// External data move steering
	input  wire logic [15:0]           xaddr,
	input  wire logic                  program_store_sel,
	// Execution status
	output logic                       instr_done_r,
	output logic                       operand_fetch_r,
	output logic                       branch_taken_r,
	output logic                       xmove_r,
	output cpu_timing_pkg::xtarget_t   xtarget_r,
	output logic [1:0]                 len_r,
	output logic [3:0]                 total_r,
	output cpu_timing_pkg::addr_mode_t mode_r,
	output logic [2:0]                 flag_mask_r
);

	typedef enum logic {ST_IDLE, ST_EXEC} exec_state_t;

	exec_state_t                state_r;
	exec_state_t                state_nxt;
	logic [3:0]                 cnt_r;
	logic [3:0]                 cnt_nxt;
	logic [1:0]                 fetch_left_r;
	logic [1:0]                 fetch_left_nxt;
	logic                       op_ready_nxt;
	logic                       instr_done_nxt;
	logic                       operand_fetch_nxt;
	logic                       branch_taken_nxt;
	logic                       xmove_nxt;
	cpu_timing_pkg::xtarget_t   xtarget_nxt;
	logic [1:0]                 len_nxt;
	logic [3:0]                 total_nxt;
	cpu_timing_pkg::addr_mode_t mode_nxt;
	logic [2:0]                 flag_mask_nxt;

	logic                       accept;
	logic [1:0]                 dec_len;
	logic [3:0]                 dec_cyc;
	logic                       dec_cond;
	cpu_timing_pkg::addr_mode_t dec_mode;
	logic [2:0]                 dec_flags;
	logic                       dec_xmove;
	logic [3:0]                 total_w;
	cpu_timing_pkg::xtarget_t   target_w;

	////////////////////////////////////////////////////////////////////////
	// Opcode decode
	cpu_opcode_decode i_cpu_opcode_decode (
		.op     (op_valid),
		.opcode (op_byte),
		.len    (dec_len),
		.cyc    (dec_cyc),
		.cond   (dec_cond),
		.mode   (dec_mode),
		.flags  (dec_flags),
		.xmove  (dec_xmove)
	);

	////////////////////////////////////////////////////////////////////////
	// Cycle total and external move target
	always_comb begin
		accept  = op_valid && op_ready_r;
		total_w = dec_cyc;
		if (dec_cond && branch_cond_true) begin
			total_w = 4'(dec_cyc + cpu_timing_pkg::BRANCH_EXTRA);
		end
		if (program_store_sel) begin
			target_w = cpu_timing_pkg::XT_FLASH;
		end else if (xaddr < EXT_RAM_LIMIT || !HAS_EXT_IF) begin
			target_w = cpu_timing_pkg::XT_EXT_RAM;
		end else begin
			target_w = cpu_timing_pkg::XT_OFFCHIP;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb begin
		state_nxt         = state_r;
		cnt_nxt           = cnt_r;
		fetch_left_nxt    = fetch_left_r;
		op_ready_nxt      = op_ready_r;
		instr_done_nxt    = 1'b0;
		operand_fetch_nxt = 1'b0;
		branch_taken_nxt  = branch_taken_r;
		xmove_nxt         = xmove_r;
		xtarget_nxt       = xtarget_r;
		len_nxt           = len_r;
		total_nxt         = total_r;
		mode_nxt          = mode_r;
		flag_mask_nxt     = flag_mask_r;
		unique case (state_r)
			ST_IDLE: begin
				if (accept) begin
					len_nxt           = dec_len;
					total_nxt         = total_w;
					mode_nxt          = dec_mode;
					flag_mask_nxt     = dec_flags;
					branch_taken_nxt  = dec_cond && branch_cond_true;
					xmove_nxt         = dec_xmove;
					xtarget_nxt       = dec_xmove ? target_w
						: cpu_timing_pkg::XT_NONE;
					fetch_left_nxt    = 2'(dec_len - cpu_timing_pkg::ONE_BYTE);
					operand_fetch_nxt = dec_len > cpu_timing_pkg::ONE_BYTE;
					if (total_w == cpu_timing_pkg::ONE_CYCLE) begin
						instr_done_nxt = 1'b1;
						xmove_nxt      = 1'b0;
					end else begin
						state_nxt    = ST_EXEC;
						op_ready_nxt = 1'b0;
						cnt_nxt      = 4'(total_w - cpu_timing_pkg::ONE_CYCLE);
					end
				end
			end
			ST_EXEC: begin
				cnt_nxt = 4'(cnt_r - cpu_timing_pkg::ONE_CYCLE);
				if (fetch_left_r != 2'h0) begin
					fetch_left_nxt = 2'(fetch_left_r - cpu_timing_pkg::ONE_BYTE);
				end
				operand_fetch_nxt = fetch_left_nxt != 2'h0;
				if (cnt_r == cpu_timing_pkg::ONE_CYCLE) begin
					state_nxt      = ST_IDLE;
					op_ready_nxt   = 1'b1;
					instr_done_nxt = 1'b1;
					xmove_nxt      = 1'b0;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r         <= ST_IDLE;
			cnt_r           <= 4'h0;
			fetch_left_r    <= 2'h0;
			op_ready_r      <= 1'b1;
			instr_done_r    <= 1'b0;
			operand_fetch_r <= 1'b0;
			branch_taken_r  <= 1'b0;
			xmove_r         <= 1'b0;
			xtarget_r       <= cpu_timing_pkg::XT_NONE;
			len_r           <= 2'h0;
			total_r         <= 4'h0;
			mode_r          <= cpu_timing_pkg::MODE_OTHER;
			flag_mask_r     <= cpu_timing_pkg::FM_NONE;
		end else begin
			state_r         <= state_nxt;
			cnt_r           <= cnt_nxt;
			fetch_left_r    <= fetch_left_nxt;
			op_ready_r      <= op_ready_nxt;
			instr_done_r    <= instr_done_nxt;
			operand_fetch_r <= operand_fetch_nxt;
			branch_taken_r  <= branch_taken_nxt;
			xmove_r         <= xmove_nxt;
			xtarget_r       <= xtarget_nxt;
			len_r           <= len_nxt;
			total_r         <= total_nxt;
			mode_r          <= mode_nxt;
			flag_mask_r     <= flag_mask_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [3:0] elapsed_r;
	logic [3:0] elapsed_nxt;

	always_comb begin
		elapsed_nxt = elapsed_r;
		if (accept) begin
			elapsed_nxt = 4'h0;
		end else if (elapsed_r != 4'hF) begin
			elapsed_nxt = 4'(elapsed_r + 4'h1);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			elapsed_r <= 4'h0;
		end else begin
			elapsed_r <= elapsed_nxt;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	property p_done_on_total;
		instr_done_r |-> elapsed_r == 4'(total_r - cpu_timing_pkg::ONE_CYCLE);
	endproperty
	a_done_on_total: assert property (p_done_on_total)
		else $error("completion not on the cycle total");

	property p_no_accept_busy;
		state_r == ST_EXEC |-> !op_ready_r;
	endproperty
	a_no_accept_busy: assert property (p_no_accept_busy)
		else $error("ready while executing");

	property p_taken_extra;
		accept && dec_cond && branch_cond_true
			|=> total_r == 4'($past(dec_cyc) + cpu_timing_pkg::BRANCH_EXTRA)
			&& branch_taken_r;
	endproperty
	a_taken_extra: assert property (p_taken_extra)
		else $error("taken branch total wrong");

	property p_not_taken;
		accept && dec_cond && !branch_cond_true
			|=> total_r == $past(dec_cyc) && !branch_taken_r;
	endproperty
	a_not_taken: assert property (p_not_taken)
		else $error("untaken branch total wrong");

	property p_acc_single;
		accept && (op_byte == cpu_timing_pkg::OP_CLR_A
			|| op_byte == cpu_timing_pkg::OP_SWAP
			|| op_byte == cpu_timing_pkg::OP_RR)
			|=> instr_done_r && op_ready_r && len_r == 2'h1;
	endproperty
	a_acc_single: assert property (p_acc_single)
		else $error("accumulator op not one cycle");

	property p_mul;
		accept && op_byte == cpu_timing_pkg::OP_MUL
			|=> !instr_done_r [*3] ##1 instr_done_r;
	endproperty
	a_mul: assert property (p_mul)
		else $error("multiply not four cycles");

	property p_div;
		accept && op_byte == cpu_timing_pkg::OP_DIV
			|=> !instr_done_r [*7] ##1 instr_done_r;
	endproperty
	a_div: assert property (p_div)
		else $error("divide not eight cycles");

	property p_move_dd;
		accept && (op_byte == cpu_timing_pkg::OP_MOV_DD
			|| op_byte == cpu_timing_pkg::OP_LD_DATA_PTR)
			|=> len_r == 2'h3 && operand_fetch_r ##1 operand_fetch_r
			##1 instr_done_r && !operand_fetch_r;
	endproperty
	a_move_dd: assert property (p_move_dd)
		else $error("three byte move timing wrong");

	property p_ind_store;
		accept && (op_byte == cpu_timing_pkg::OP_ST_IND0
			|| op_byte == cpu_timing_pkg::OP_ST_IND1)
			|=> len_r == 2'h1 && !operand_fetch_r ##1 instr_done_r;
	endproperty
	a_ind_store: assert property (p_ind_store)
		else $error("indirect store not two cycles");

	property p_code_read;
		accept && (op_byte == cpu_timing_pkg::OP_CODE_PC
			|| op_byte == cpu_timing_pkg::OP_CODE_DP)
			|=> !instr_done_r [*2] ##1 instr_done_r;
	endproperty
	a_code_read: assert property (p_code_read)
		else $error("code byte read not three cycles");

	property p_xmove;
		accept && dec_xmove
			|=> xmove_r && xtarget_r != cpu_timing_pkg::XT_NONE
			##1 xmove_r ##1 instr_done_r && !xmove_r;
	endproperty
	a_xmove: assert property (p_xmove)
		else $error("external move not three cycles");

	property p_flash_target;
		accept && dec_xmove && program_store_sel
			|=> xtarget_r == cpu_timing_pkg::XT_FLASH;
	endproperty
	a_flash_target: assert property (p_flash_target)
		else $error("flash target not chosen");

	property p_arith_flags;
		accept && dec_len == 2'h1 && op_byte[3] && !op_byte[7]
			&& op_byte[5] && !op_byte[6]
			|=> flag_mask_r == cpu_timing_pkg::FM_ARITH
			&& mode_r == cpu_timing_pkg::MODE_REG && total_r == 4'h1;
	endproperty
	a_arith_flags: assert property (p_arith_flags)
		else $error("register add decode wrong");

endmodule

// [cpu_timing_pkg.sv]
// Constants, timing tables and types for the instruction timing block
package cpu_timing_pkg;

	typedef enum logic [2:0] {
		MODE_REG, MODE_IND, MODE_DIR, MODE_IMM, MODE_IMPLIED, MODE_OTHER
	} addr_mode_t;

	typedef enum logic [1:0] {
		XT_NONE, XT_EXT_RAM, XT_OFFCHIP, XT_FLASH
	} xtarget_t;

	// Timing entry: [7] conditional branch, [5:4] bytes, [3:0] cycles
	localparam int TIM_COND   = 7;
	localparam int TIM_LEN_HI = 5;
	localparam int TIM_LEN_LO = 4;
	localparam int TIM_CYC_HI = 3;
	localparam int TIM_CYC_LO = 0;

	// Timing per opcode column, indexed by the high nibble (row F first)
	localparam logic [15:0][7:0] TAB_BRANCH = {
		8'h13, 8'h13, 8'h22, 8'h22, 8'h22, 8'h22, 8'h33, 8'h24,
		8'hA2, 8'hA2, 8'hA2, 8'hA2, 8'hB3, 8'hB3, 8'hB3, 8'h11};
	localparam logic [7:0]       TAB_ABS    = 8'h24;
	localparam logic [15:0][7:0] TAB_LONG   = {
		8'h13, 8'h13, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22,
		8'h22, 8'h22, 8'h22, 8'h22, 8'h16, 8'h16, 8'h35, 8'h35};
	localparam logic [15:0][7:0] TAB_MISC   = {
		8'h13, 8'h13, 8'h11, 8'h11, 8'h11, 8'h11, 8'h13, 8'h13,
		8'h14, 8'h33, 8'h33, 8'h33, 8'h11, 8'h11, 8'h11, 8'h11};
	localparam logic [15:0][7:0] TAB_ACC    = {
		8'h11, 8'h11, 8'h11, 8'h11, 8'hB3, 8'h14, 8'h22, 8'h18,
		8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h11, 8'h11};
	localparam logic [15:0][7:0] TAB_DIR    = {
		8'h22, 8'h22, 8'hB3, 8'h22, 8'hB3, 8'h11, 8'h22, 8'h33,
		8'h33, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22};
	localparam logic [15:0][7:0] TAB_IND    = {
		8'h12, 8'h12, 8'h12, 8'h12, 8'hB4, 8'h22, 8'h12, 8'h22,
		8'h22, 8'h12, 8'h12, 8'h12, 8'h12, 8'h12, 8'h12, 8'h12};
	localparam logic [15:0][7:0] TAB_REG    = {
		8'h11, 8'h11, 8'hA2, 8'h11, 8'hB3, 8'h22, 8'h11, 8'h22,
		8'h22, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11};

	// Opcode columns and row masks
	localparam logic [3:0]  COL_BRANCH = 4'h0;
	localparam logic [3:0]  COL_ABS    = 4'h1;
	localparam logic [3:0]  COL_LONG   = 4'h2;
	localparam logic [3:0]  COL_MISC   = 4'h3;
	localparam logic [3:0]  COL_ACC    = 4'h4;
	localparam logic [3:0]  COL_DIR    = 4'h5;
	localparam logic [3:0]  COL_IND_LO = 4'h6;
	localparam logic [3:0]  COL_REG    = 4'h8;
	localparam logic [3:0]  ROW_CJNE   = 4'hB;
	localparam logic [15:0] ROWS_IMM   = 16'h0AFC;
	localparam logic [15:0] ROWS_ARITH = 16'h020C;
	localparam logic [15:0] ROWS_XMOVE = 16'hC000;
	localparam logic [15:0] COLS_XMOVE = 16'h000D;

	// Flag effect mask {carry, aux carry, overflow}
	localparam logic [2:0] FM_NONE  = 3'h0;
	localparam logic [2:0] FM_ARITH = 3'h7;
	localparam logic [2:0] FM_CY_OV = 3'h5;
	localparam logic [2:0] FM_CY    = 3'h4;

	// Single opcodes
	localparam logic [7:0] OP_MUL      = 8'hA4;
	localparam logic [7:0] OP_DIV      = 8'h84;
	localparam logic [7:0] OP_DA       = 8'hD4;
	localparam logic [7:0] OP_RRC      = 8'h13;
	localparam logic [7:0] OP_RLC      = 8'h33;
	localparam logic [7:0] OP_CLR_C    = 8'hC3;
	localparam logic [7:0] OP_SETB_C   = 8'hD3;
	localparam logic [7:0] OP_CPL_C    = 8'hB3;
	localparam logic [7:0] OP_MOV_CBIT = 8'hA2;
	localparam logic [7:0] OP_ORL_C    = 8'h72;
	localparam logic [7:0] OP_ANL_C    = 8'h82;
	localparam logic [7:0] OP_ORL_NC   = 8'hA0;
	localparam logic [7:0] OP_ANL_NC   = 8'hB0;
	localparam logic [7:0] OP_MOV_DD   = 8'h85;
	localparam logic [7:0] OP_LD_DATA_PTR = 8'h90;
	localparam logic [7:0] OP_CODE_PC  = 8'h83;
	localparam logic [7:0] OP_CODE_DP  = 8'h93;
	localparam logic [7:0] OP_ST_IND0  = 8'hF6;
	localparam logic [7:0] OP_ST_IND1  = 8'hF7;
	localparam logic [7:0] OP_CLR_A    = 8'hE4;
	localparam logic [7:0] OP_SWAP     = 8'hC4;
	localparam logic [7:0] OP_RR       = 8'h03;

	// Timing constants
	localparam logic [3:0]  BRANCH_EXTRA       = 4'h2;
	localparam logic [3:0]  ONE_CYCLE          = 4'h1;
	localparam logic [1:0]  ONE_BYTE           = 2'h1;
	localparam logic [15:0] EXT_RAM_LIMIT_DEFAULT = 16'h0800;

endpackage

// [cpu_opcode_decode.sv]
// Opcode decoder: length, cycles, addressing mode and flag effects
`timescale 1ns/100ps
module cpu_opcode_decode (
	// Opcode
	input  wire logic                      op,
	input  wire logic [7:0]                opcode,
	// Decoded attributes
	output logic [1:0]                     len,
	output logic [3:0]                     cyc,
	output logic                           cond,
	output cpu_timing_pkg::addr_mode_t     mode,
	output logic [2:0]                     flags,
	output logic                           xmove
);

	logic [3:0] hi;
	logic [3:0] lo;
	logic [7:0] entry;

	////////////////////////////////////////////////////////////////////////
	// Timing lookup
	always_comb begin
		hi = opcode[7:4];
		lo = opcode[3:0];
		if (lo >= cpu_timing_pkg::COL_REG) begin
			entry = cpu_timing_pkg::TAB_REG[hi];
		end else if (lo >= cpu_timing_pkg::COL_IND_LO) begin
			entry = cpu_timing_pkg::TAB_IND[hi];
		end else if (lo == cpu_timing_pkg::COL_DIR) begin
			entry = cpu_timing_pkg::TAB_DIR[hi];
		end else if (lo == cpu_timing_pkg::COL_ACC) begin
			entry = cpu_timing_pkg::TAB_ACC[hi];
		end else if (lo == cpu_timing_pkg::COL_MISC) begin
			entry = cpu_timing_pkg::TAB_MISC[hi];
		end else if (lo == cpu_timing_pkg::COL_LONG) begin
			entry = cpu_timing_pkg::TAB_LONG[hi];
		end else if (lo == cpu_timing_pkg::COL_ABS) begin
			entry = cpu_timing_pkg::TAB_ABS;
		end else begin
			entry = cpu_timing_pkg::TAB_BRANCH[hi];
		end
		len   = op ? entry[cpu_timing_pkg::TIM_LEN_HI:
			cpu_timing_pkg::TIM_LEN_LO] : 2'h0;
		cyc   = op ? entry[cpu_timing_pkg::TIM_CYC_HI:
			cpu_timing_pkg::TIM_CYC_LO] : 4'h0;
		cond  = op & entry[cpu_timing_pkg::TIM_COND];
		xmove = op & cpu_timing_pkg::ROWS_XMOVE[hi]
			& cpu_timing_pkg::COLS_XMOVE[lo];
	end

	////////////////////////////////////////////////////////////////////////
	// Addressing mode and flag effects
	always_comb begin
		if (lo >= cpu_timing_pkg::COL_REG) begin
			mode = cpu_timing_pkg::MODE_REG;
		end else if (lo >= cpu_timing_pkg::COL_IND_LO) begin
			mode = cpu_timing_pkg::MODE_IND;
		end else if (lo == cpu_timing_pkg::COL_DIR) begin
			mode = cpu_timing_pkg::MODE_DIR;
		end else if (lo == cpu_timing_pkg::COL_ACC) begin
			mode = cpu_timing_pkg::ROWS_IMM[hi] ? cpu_timing_pkg::MODE_IMM
				: cpu_timing_pkg::MODE_IMPLIED;
		end else begin
			mode = cpu_timing_pkg::MODE_OTHER;
		end
		flags = cpu_timing_pkg::FM_NONE;
		if (lo >= cpu_timing_pkg::COL_ACC
			&& cpu_timing_pkg::ROWS_ARITH[hi]) begin
			flags = cpu_timing_pkg::FM_ARITH;
		end else if (lo >= cpu_timing_pkg::COL_ACC
			&& hi == cpu_timing_pkg::ROW_CJNE) begin
			flags = cpu_timing_pkg::FM_CY;
		end
		unique case (opcode)
			cpu_timing_pkg::OP_MUL, cpu_timing_pkg::OP_DIV: begin
				flags = cpu_timing_pkg::FM_CY_OV;
			end
			cpu_timing_pkg::OP_DA, cpu_timing_pkg::OP_RRC,
			cpu_timing_pkg::OP_RLC, cpu_timing_pkg::OP_CLR_C,
			cpu_timing_pkg::OP_SETB_C, cpu_timing_pkg::OP_CPL_C,
			cpu_timing_pkg::OP_MOV_CBIT, cpu_timing_pkg::OP_ORL_C,
			cpu_timing_pkg::OP_ANL_C, cpu_timing_pkg::OP_ORL_NC,
			cpu_timing_pkg::OP_ANL_NC: begin
				flags = cpu_timing_pkg::FM_CY;
			end
			default: begin
				flags = flags;
			end
		endcase
	end

endmodule

// [program_feed.sv]
// Program memory model: offers queued opcodes to the core
`timescale 1ns/100ps
module program_feed (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// Opcode hand-off to the core
	input  wire logic        op_ready_r,
	output logic             op_valid,
	output logic [7:0]       op_byte,
	output logic             branch_cond_true,
	output logic [15:0]      xaddr,
	output logic             program_store_sel
);
	logic [25:0] fifo [$];
	logic [25:0] ent;
	logic        taken;

	initial begin
		op_valid          = 1'b0;
		op_byte           = 8'h00;
		branch_cond_true  = 1'b0;
		xaddr             = 16'h0000;
		program_store_sel = 1'b0;
		taken             = 1'b0;
	end

	task automatic push(input logic [7:0] op, input logic c,
		input logic [15:0] a, input logic s);
		fifo.push_back({op, c, a, s});
	endtask

	////////////////////////////////////////////////////////////////////
	// Acceptance seen at the rising edge
	always @(posedge clock) begin
		taken <= resetn && op_valid && op_ready_r;
	end

	// Hold an offer until taken; released opcode and address lines do not keep old values
	always @(negedge clock) begin
		if (taken || !op_valid) begin
			if (fifo.size() > 0) begin
				ent = fifo.pop_front();
				op_valid <= 1'b1;
				{op_byte, branch_cond_true, xaddr, program_store_sel} <= ent;
			end else begin
				op_valid <= 1'b0;
				op_byte  <= ~op_byte;
				xaddr    <= ~xaddr;
			end
		end
	end
endmodule

// [testbench.sv]
// Self-checking testbench for the instruction timing block
`timescale 1ns/100ps
module testbench;
	localparam logic [15:0] XLIM = 16'h0800;
	logic                       clock;
	logic                       resetn;
	logic                       op_valid;
	logic [7:0]                 op_byte;
	logic                       branch_cond_true;
	logic                       op_ready_r;
	logic [15:0]                xaddr;
	logic                       program_store_sel;
	logic                       instr_done_r;
	logic                       operand_fetch_r;
	logic                       branch_taken_r;
	logic                       xmove_r;
	cpu_timing_pkg::xtarget_t   xtarget_r;
	logic [1:0]                 len_r;
	logic [3:0]                 total_r;
	cpu_timing_pkg::addr_mode_t mode_r;
	logic [2:0]                 flag_mask_r;
	int                         fails = 0;
	int                         comparisons = 0;
	int                         cyc = 0;
	int                         acc_cyc = 0;
	int                         done_cyc = 0;
	int                         n_done = 0;
	int                         n_fetch = 0;
	int                         n_xm = 0;
	int                         n_busy = 0;

	cpu_instruction_timing #(
		.HAS_EXT_IF        (1'b1),
		.EXT_RAM_LIMIT     (XLIM)
	) i_cpu_instruction_timing (
		.clock             (clock),
		.resetn            (resetn),
		.op_valid          (op_valid),
		.op_byte           (op_byte),
		.branch_cond_true  (branch_cond_true),
		.op_ready_r        (op_ready_r),
		.xaddr             (xaddr),
		.program_store_sel (program_store_sel),
		.instr_done_r      (instr_done_r),
		.operand_fetch_r   (operand_fetch_r),
		.branch_taken_r    (branch_taken_r),
		.xmove_r           (xmove_r),
		.xtarget_r         (xtarget_r),
		.len_r             (len_r),
		.total_r           (total_r),
		.mode_r            (mode_r),
		.flag_mask_r       (flag_mask_r)
	);
	program_feed i_program_feed (
		.clock             (clock),
		.resetn            (resetn),
		.op_ready_r        (op_ready_r),
		.op_valid          (op_valid),
		.op_byte           (op_byte),
		.branch_cond_true  (branch_cond_true),
		.xaddr             (xaddr),
		.program_store_sel (program_store_sel)
	);

	////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Cycle bookkeeping of each instruction
	always @(posedge clock) begin
		if (op_valid && op_ready_r) begin
			acc_cyc = cyc;
			n_fetch = 0;
			n_xm = 0;
			n_busy = 0;
		end else begin
			if (operand_fetch_r === 1'b1) n_fetch++;
			if (op_ready_r === 1'b0) n_busy++;
			if (xmove_r === 1'b1) n_xm++;
		end
		if (instr_done_r === 1'b1) begin
			done_cyc = cyc;
			n_done++;
		end
		cyc++;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h",
				$time, what, seen, exp);
		end
	endtask

	task automatic run_op(input logic [7:0] op, input logic c,
		input logic [15:0] a, input logic s, input logic [1:0] len,
		input logic [3:0] n, input logic [2:0] md, input logic [2:0] fl);
		int d;
		d = n_done;
		@(posedge clock);
		#1;
		i_program_feed.push(op, c, a, s);
		for (int i = 0; i < 40 && n_done == d; i++) @(negedge clock);
		check(16'(n_done - d), 16'h0001, "done pulse");
		check(16'(done_cyc - acc_cyc), 16'(n), "elapsed");
		check(16'(total_r), 16'(n), "total");
		check(16'(len_r), 16'(len), "length");
		check(16'(n_fetch), 16'(len - 1), "operand fetches");
		check(16'(n_busy), 16'(n - 1), "busy cycles");
		check(16'(flag_mask_r), 16'(fl), "flag mask");
		if (md != 3'h7) check(16'(mode_r), 16'(md), "mode");
	endtask

	task automatic op1(input logic [7:0] op, input logic [1:0] len,
		input logic [3:0] n, input logic [2:0] md, input logic [2:0] fl);
		run_op(op, 1'b0, 16'h0000, 1'b0, len, n, md, fl);
	endtask

	task automatic test_arith;
		op1(8'h28, 2'h1, 4'h1, 3'h0, 3'h7);
		op1(8'h25, 2'h2, 4'h2, 3'h2, 3'h7);
		op1(8'h26, 2'h1, 4'h2, 3'h1, 3'h7);
		op1(8'h24, 2'h2, 4'h2, 3'h3, 3'h7);
		op1(8'h3F, 2'h1, 4'h1, 3'h0, 3'h7);
		op1(8'h37, 2'h1, 4'h2, 3'h1, 3'h7);
		op1(8'h35, 2'h2, 4'h2, 3'h2, 3'h7);
		op1(8'h34, 2'h2, 4'h2, 3'h3, 3'h7);
		op1(8'h98, 2'h1, 4'h1, 3'h0, 3'h7);
		op1(8'h95, 2'h2, 4'h2, 3'h2, 3'h7);
		op1(8'h96, 2'h1, 4'h2, 3'h1, 3'h7);
		op1(8'h94, 2'h2, 4'h2, 3'h3, 3'h7);
	endtask

	task automatic test_logic;
		op1(8'h52, 2'h2, 4'h2, 3'h7, 3'h0);
		op1(8'h53, 2'h3, 4'h3, 3'h7, 3'h0);
		op1(8'h42, 2'h2, 4'h2, 3'h7, 3'h0);
		op1(8'h43, 2'h3, 4'h3, 3'h7, 3'h0);
		op1(8'h62, 2'h2, 4'h2, 3'h7, 3'h0);
		op1(8'h63, 2'h3, 4'h3, 3'h7, 3'h0);
		op1(8'hE4, 2'h1, 4'h1, 3'h4, 3'h0);
		op1(8'hF4, 2'h1, 4'h1, 3'h4, 3'h0);
		op1(8'h23, 2'h1, 4'h1, 3'h7, 3'h0);
		op1(8'h33, 2'h1, 4'h1, 3'h7, 3'h4);
		op1(8'h03, 2'h1, 4'h1, 3'h7, 3'h0);
		op1(8'h13, 2'h1, 4'h1, 3'h7, 3'h4);
		op1(8'hC4, 2'h1, 4'h1, 3'h4, 3'h0);
	endtask

	task automatic test_transfer;
		op1(8'h85, 2'h3, 4'h3, 3'h7, 3'h0);
		op1(8'hF6, 2'h1, 4'h2, 3'h1, 3'h0);
		op1(8'h90, 2'h3, 4'h3, 3'h7, 3'h0);
		op1(8'h93, 2'h1, 4'h3, 3'h7, 3'h0);
		op1(8'h83, 2'h1, 4'h3, 3'h7, 3'h0);
		op1(8'hC0, 2'h2, 4'h2, 3'h7, 3'h0);
		op1(8'hD0, 2'h2, 4'h2, 3'h7, 3'h0);
		op1(8'hC8, 2'h1, 4'h1, 3'h0, 3'h0);
		op1(8'hC5, 2'h2, 4'h2, 3'h2, 3'h0);
		op1(8'hC6, 2'h1, 4'h2, 3'h1, 3'h0);
		op1(8'hD6, 2'h1, 4'h2, 3'h1, 3'h0);
		op1(8'hA4, 2'h1, 4'h4, 3'h7, 3'h5);
		op1(8'h84, 2'h1, 4'h8, 3'h7, 3'h5);
	endtask

	task automatic test_branch;
		run_op(8'h40, 1'b1, 16'h0, 1'b0, 2'h2, 4'h4, 3'h7, 3'h0);
		check(16'(branch_taken_r), 16'h0001, "taken");
		run_op(8'h40, 1'b0, 16'h0, 1'b0, 2'h2, 4'h2, 3'h7, 3'h0);
		check(16'(branch_taken_r), 16'h0000, "not taken");
		run_op(8'h20, 1'b1, 16'h0, 1'b0, 2'h3, 4'h5, 3'h7, 3'h0);
		run_op(8'h20, 1'b0, 16'h0, 1'b0, 2'h3, 4'h3, 3'h7, 3'h0);
		run_op(8'hB6, 1'b1, 16'h0, 1'b0, 2'h3, 4'h6, 3'h7, 3'h4);
		run_op(8'hB6, 1'b0, 16'h0, 1'b0, 2'h3, 4'h4, 3'h7, 3'h4);
	endtask

	task automatic test_xmove;
		run_op(8'hE0, 1'b0, 16'(XLIM - 16'h0001), 1'b0, 2'h1, 4'h3,
			3'h7, 3'h0);
		check(16'(xtarget_r), 16'h0001, "on-chip target");
		check(16'(n_xm), 16'h0002, "move cycles");
		run_op(8'hF0, 1'b0, XLIM, 1'b0, 2'h1, 4'h3, 3'h7, 3'h0);
		check(16'(xtarget_r), 16'h0002, "off-chip target");
		run_op(8'hE3, 1'b0, 16'h0010, 1'b1, 2'h1, 4'h3, 3'h7, 3'h0);
		check(16'(xtarget_r), 16'h0003, "flash target");
		run_op(8'hF2, 1'b0, 16'hFFFF, 1'b1, 2'h1, 4'h3, 3'h7, 3'h0);
		check(16'(xtarget_r), 16'h0003, "flash high");
	endtask

	task automatic test_back_to_back;
		int d;
		int c0;
		d = n_done;
		@(posedge clock);
		#1;
		c0 = cyc;
		i_program_feed.push(8'hE4, 1'b0, 16'h0000, 1'b0);
		i_program_feed.push(8'hF4, 1'b0, 16'h0000, 1'b0);
		i_program_feed.push(8'hC4, 1'b0, 16'h0000, 1'b0);
		for (int i = 0; i < 20 && n_done != d + 3; i++) @(negedge clock);
		check(16'(n_done - d), 16'h0003, "pulses");
		check(16'(done_cyc - c0), 16'h0003, "back to back");
	endtask

	task automatic finish_test;
		$display("Comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		#(20000 * 50);
		fails++;
		finish_test;
	end

	initial begin
		resetn = 1'b0;
		repeat (10) @(negedge clock);
		resetn = 1'b1;
		test_arith;
		test_logic;
		test_transfer;
		test_branch;
		test_xmove;
		test_back_to_back;
		finish_test;
	end
endmodule
